// >>> fpsq_core.sv
// fault protection sequencer with its register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module fpsq_core import fpsq_pkg::*; #(
    parameter int LONG_OFF_P = LONG_OFF_CYC,
    parameter int SC_PULSE_P = SC_PULSE_CYC,
    parameter int SC_REACH_P = SC_REACH_CYC,
    parameter int BO_BLANK_P = BO_BLANK_CYC,
    parameter int RECOVER_P = RECOVER_CYC,
    parameter bit SHORT_DET_EN = 1'b1,
    parameter bit BROWNOUT_EN = 1'b1,
    parameter bit ONTIME_MOD_EN = 1'b1,
    parameter bit OC_LATCHED = 1'b0
) (
    input logic clk_sys,
    input logic rst,
    input fpsq_cmp_t cmp_in,
    input logic gate_drive,
    output logic gate_en,
    output logic startup_en,
    output logic fault_mode,
    output logic ontime_mod_en,
    input logic [7:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready
);
    localparam logic [7:0] BLANK_C = 8'(OVP_BLANK_CYC);
    localparam logic [15:0] LONG_C = 16'(LONG_OFF_P);
    localparam logic [15:0] PULSE_C = 16'(SC_PULSE_P);
    localparam logic [27:0] CHG_C = 28'(SC_CHARGE_W);
    localparam logic [27:0] THR_C = 28'(SC_REACH_P * SC_CHARGE_W);
    localparam logic [27:0] BO_C = 28'(BO_BLANK_P);
    localparam logic [27:0] REC_C = 28'(RECOVER_P);
    localparam logic [2:0] OV_LAST = 3'(OVP_EVENTS - 1);

    fpsq_regs_t q_r;
    fpsq_regs_t q_nxt;
    logic ov_evt;

    always_comb begin
        fpsq_cmp_t c;
        logic off;
        logic long_evt;
        logic ov_trip;
        logic short_trip;
        logic line_ok;
        logic [31:0] stat;
        c = q_r.s2;
        off = !gate_drive;
        long_evt = 1'b0;
        ov_trip = 1'b0;
        short_trip = 1'b0;
        line_ok = 1'b0;
        stat = '0;
        q_nxt = q_r;
        // second stage only is read: first stage may be metastable
        q_nxt.s1 = cmp_in;
        q_nxt.s2 = q_r.s1;
        q_nxt.gate_d = gate_drive;

        // off-period timing and overvoltage sampling
        if (!off) begin
            q_nxt.blank_cnt = '0;
            q_nxt.ov_seen = 1'b0;
            q_nxt.off_cnt = '0;
            q_nxt.long_done = 1'b0;
        end else begin
            if (q_r.blank_cnt != BLANK_C) begin
                q_nxt.blank_cnt = q_r.blank_cnt + 8'h01;
            end
            if (q_r.off_cnt != LONG_C) begin
                q_nxt.off_cnt = q_r.off_cnt + 16'h0001;
            end
        end
        ov_evt = off && q_r.st == ST_RUN && q_r.blank_cnt == BLANK_C
            && c.output_overvoltage_check && !q_r.ov_seen;
        if (ov_evt) begin
            q_nxt.ov_seen = 1'b1;
            q_nxt.ov_cnt = q_r.ov_cnt + 3'h1;
            ov_trip = q_r.ov_cnt == OV_LAST;
        end
        if (gate_drive && !q_r.gate_d && !q_r.ov_seen) begin
            q_nxt.ov_cnt = '0;
        end

        // long off-time and short-circuit integrator
        long_evt = off && q_r.off_cnt == LONG_C && !q_r.long_done;
        if (long_evt) begin
            q_nxt.long_done = 1'b1;
            q_nxt.pulse_cnt = PULSE_C;
        end else if (q_r.pulse_cnt != '0) begin
            q_nxt.pulse_cnt = q_r.pulse_cnt - 16'h0001;
        end
        if (q_r.st != ST_RUN) begin
            q_nxt.integ = '0;
        end else if (q_r.pulse_cnt != '0) begin
            // saturates so that a long stream cannot wrap
            q_nxt.integ = (q_r.integ >= THR_C - CHG_C) ? THR_C
                : q_r.integ + CHG_C;
        end else if (q_r.integ != '0) begin
            q_nxt.integ = q_r.integ - 28'h1;
        end
        short_trip = SHORT_DET_EN && q_r.st == ST_RUN
            && q_r.integ >= THR_C;

        // brown-out flag; set wins over a clear in the same cycle
        if (BROWNOUT_EN) begin
            if (!c.line_below_stop) begin
                q_nxt.bo_cnt = '0;
            end else if (q_r.bo_cnt != BO_C) begin
                q_nxt.bo_cnt = q_r.bo_cnt + 28'h1;
            end
            if (c.line_above_start) begin
                q_nxt.bo_flag = 1'b0;
            end
            if (c.line_below_stop && q_r.bo_cnt == BO_C) begin
                q_nxt.bo_flag = 1'b1;
            end
        end
        line_ok = !BROWNOUT_EN || c.line_above_start;

        case (q_r.st)
            ST_WAIT: begin
                if (c.supply_at_on && !c.supply_lockout && line_ok) begin
                    q_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (c.supply_lockout || short_trip || ov_trip
                    || (c.oc_fault && !OC_LATCHED)) begin
                    q_nxt.st = ST_FAULT;
                    q_nxt.rec = '0;
                    q_nxt.cause = {c.supply_lockout || c.oc_fault,
                        short_trip, ov_trip};
                end else if (c.oc_fault) begin
                    q_nxt.st = ST_LATCH;
                    q_nxt.cause = 3'h4;
                end else if (q_r.bo_flag && c.zero_cross) begin
                    q_nxt.st = ST_BROWN;
                end
            end
            ST_BROWN: begin
                if (c.line_above_start) begin
                    q_nxt.st = ST_WAIT;
                end
            end
            ST_FAULT: begin
                q_nxt.rec = q_r.rec + 28'h1;
                if (q_r.rec == REC_C - 28'h1) begin
                    q_nxt.st = ST_WAIT;
                end
            end
            ST_LATCH: begin
                // latched handling leaves as soon as the supply falls below reset
                if (c.supply_below_reset) begin
                    q_nxt.st = ST_WAIT;
                end
            end
            ST_THERM: begin
                if (c.supply_below_reset) begin
                    q_nxt.startup_en = 1'b1;
                end
                if (c.supply_at_on && q_r.startup_en) begin
                    q_nxt.startup_en = 1'b0;
                    if (!c.overtemp) begin
                        q_nxt.st = ST_WAIT;
                    end
                end
            end
            default: begin
                q_nxt.st = ST_WAIT;
            end
        endcase
        if (c.overtemp && q_r.st != ST_THERM) begin
            q_nxt.st = ST_THERM;
            q_nxt.startup_en = 1'b0;
            q_nxt.cause = 3'h0;
        end
        if (q_nxt.st != ST_THERM) begin
            q_nxt.startup_en = 1'b1;
        end
        if (q_nxt.st != ST_RUN) begin
            q_nxt.ov_cnt = '0;
        end
        q_nxt.gate_en = q_nxt.st == ST_RUN && !q_r.sw_dis;
        q_nxt.fault_mode = q_nxt.st == ST_FAULT || q_nxt.st == ST_LATCH
            || q_nxt.st == ST_THERM;
        q_nxt.ontime_en = ONTIME_MOD_EN;

        // register slave, write side
        if (s_axi_awvalid && q_r.awready) begin
            q_nxt.awaddr = s_axi_awaddr;
            q_nxt.aw_held = 1'b1;
            q_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && q_r.wready) begin
            q_nxt.wdata = s_axi_wdata;
            q_nxt.wstrb = s_axi_wstrb;
            q_nxt.w_held = 1'b1;
            q_nxt.wready = 1'b0;
        end
        if (q_r.aw_held && q_r.w_held && !q_r.bvalid) begin
            q_nxt.aw_held = 1'b0;
            q_nxt.w_held = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = RESP_OKAY;
            case ({q_r.awaddr[7:2], 2'b00})
                REG_CTRL: begin
                    if (q_r.wstrb[0]) begin
                        q_nxt.sw_dis = q_r.wdata[CTRL_SW_DIS_BIT];
                    end
                end
                REG_STATUS, REG_INTEG: begin
                    q_nxt.bresp = RESP_OKAY;
                end
                default: begin
                    q_nxt.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (q_r.bvalid && s_axi_bready) begin
            q_nxt.bvalid = 1'b0;
            q_nxt.awready = 1'b1;
            q_nxt.wready = 1'b1;
        end

        // register slave, read side
        stat[STAT_ST_LSB +: 3] = q_r.st;
        stat[STAT_BO_BIT] = q_r.bo_flag;
        stat[STAT_OVCNT_LSB +: 3] = q_r.ov_cnt;
        stat[STAT_STARTUP_BIT] = q_r.startup_en;
        stat[STAT_GATE_BIT] = q_r.gate_en;
        stat[STAT_CAUSE_LSB +: 3] = q_r.cause;
        if (s_axi_arvalid && q_r.arready) begin
            q_nxt.arready = 1'b0;
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp = RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                REG_CTRL: begin
                    q_nxt.rdata = {31'h0, q_r.sw_dis};
                end
                REG_STATUS: begin
                    q_nxt.rdata = stat;
                end
                REG_INTEG: begin
                    q_nxt.rdata = {4'h0, q_r.integ};
                end
                default: begin
                    q_nxt.rdata = '0;
                    q_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (q_r.rvalid && s_axi_rready) begin
            q_nxt.rvalid = 1'b0;
            q_nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_r <= REGS_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign gate_en = q_r.gate_en;
    assign startup_en = q_r.startup_en;
    assign fault_mode = q_r.fault_mode;
    assign ontime_mod_en = q_r.ontime_en;
    assign s_axi_awready = q_r.awready;
    assign s_axi_wready = q_r.wready;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_arready = q_r.arready;
    assign s_axi_rvalid = q_r.rvalid;
    assign s_axi_rdata = q_r.rdata;
    assign s_axi_rresp = q_r.rresp;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_bo_zero;
        q_r.st == ST_RUN && q_r.bo_flag && q_r.s2.zero_cross
            && !q_r.s2.overtemp && !q_r.s2.supply_lockout
            && !q_r.s2.oc_fault && !ov_evt && q_r.integ < THR_C;
    endsequence

    sequence s_therm_at_on;
        q_r.st == ST_THERM && q_r.startup_en ##1 q_r.s2.overtemp
            && q_r.s2.supply_at_on;
    endsequence

    // fourth event clears the count on fault entry, so only RUN keeps it
    a_ovp_blank_off: assert property ($rose(q_r.ov_seen) |->
        $past(q_r.blank_cnt) == BLANK_C
        && (q_r.ov_cnt != 3'h0 || q_r.st != ST_RUN))
        else $error("overvoltage event inside blanking");
    a_ovp_fourth: assert property (ov_evt && q_r.ov_cnt == OV_LAST
        && !q_r.s2.overtemp |=> q_r.st == ST_FAULT && q_r.ov_cnt == 3'h0)
        else $error("fourth overvoltage event did not fault");
    a_ovcnt_clear: assert property (gate_drive && !q_r.gate_d
        && !q_r.ov_seen |=> q_r.ov_cnt == 3'h0)
        else $error("overvoltage count kept after clean cycle");
    a_long_pulse: assert property (!gate_drive && q_r.off_cnt == LONG_C
        && !q_r.long_done |=> q_r.pulse_cnt == PULSE_C)
        else $error("long off-time did not start pulse");
    a_integ_charge: assert property (q_r.st == ST_RUN
        && q_r.pulse_cnt != '0 && q_r.integ < THR_C - CHG_C
        |=> q_r.integ == $past(q_r.integ) + CHG_C)
        else $error("integrator charge step wrong");
    a_integ_drain: assert property (q_r.st == ST_RUN
        && q_r.pulse_cnt == '0 && q_r.integ != '0
        |=> q_r.integ == $past(q_r.integ) - 28'h1)
        else $error("integrator discharge step wrong");
    a_short_trip: assert property (SHORT_DET_EN && q_r.st == ST_RUN
        && q_r.integ >= THR_C |=> q_r.fault_mode && !q_r.gate_en)
        else $error("short threshold did not stop switching");
    a_bo_blank: assert property ($rose(q_r.bo_flag) |->
        $past(q_r.bo_cnt) == BO_C)
        else $error("brown-out flag set before blanking");
    a_bo_zero_stop: assert property (s_bo_zero |=> q_r.st == ST_BROWN
        && !q_r.gate_en)
        else $error("brown-out did not stop at zero crossing");
    a_line_gate: assert property (BROWNOUT_EN && q_r.st == ST_WAIT
        && !q_r.s2.line_above_start |=> q_r.st != ST_RUN)
        else $error("started below startup threshold");
    a_therm_entry: assert property (q_r.s2.overtemp
        && q_r.st != ST_THERM |=> q_r.st == ST_THERM
        && !q_r.startup_en && !q_r.gate_en)
        else $error("over-temperature did not shut down");
    a_therm_hold: assert property (s_therm_at_on |=> q_r.st == ST_THERM
        && !q_r.startup_en)
        else $error("restart with over-temperature present");
    a_recover_end: assert property (q_r.st == ST_FAULT
        && q_r.rec == REC_C - 28'h1 && !q_r.s2.overtemp
        |=> q_r.st == ST_WAIT)
        else $error("auto-recovery timer did not end fault");
    a_sync_depth: assert property (!$past(rst, 2)
        |-> q_r.s2 == $past(cmp_in, 2))
        else $error("comparator synchroniser depth wrong");
endmodule // fpsq_core

// >>> fpsq_far_model.sv
// front-end comparator and gate driver model for the sequencer bench
`timescale 1ns/10ps
module fpsq_far_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic gate_en,
    input wire logic [15:0] off_len,
    input wire logic [15:0] ovp_at,
    output logic gate_drive,
    output logic output_overvoltage_check
);
    int cnt;
    // 20 cycles on, off_len cycles off; stops dead when pulses are gated
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            gate_drive <= 1'b0;
            output_overvoltage_check <= 1'b0;
        end else begin
            cnt <= (!gate_en || cnt >= 19 + off_len) ? 0 : cnt + 1;
            gate_drive <= gate_en && cnt < 20;
            // three-cycle trip at a set point of the off-period
            output_overvoltage_check <= ovp_at != 0 && cnt >= 20 + ovp_at && cnt < 23 + ovp_at;
        end
    end
endmodule // fpsq_far_model

// >>> fpsq_pkg.sv
// constants, state codes and carriers for the fault protection sequencer
package fpsq_pkg;
    localparam int CLK_NS = 8;
    localparam int OVP_EVENTS = 4;
    localparam int OVP_BLANK_NS = 2000;
    localparam int OVP_BLANK_CYC = (OVP_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int LONG_OFF_NS = 50000;
    localparam int LONG_OFF_CYC = (LONG_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SC_PULSE_NS = 150000;
    localparam int SC_PULSE_CYC = (SC_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SC_CHARGE_W = 20;
    localparam int SC_REACH_NS = 40000000;
    localparam int SC_REACH_CYC = SC_REACH_NS / CLK_NS;
    localparam int BO_BLANK_NS = 54000000;
    localparam int BO_BLANK_CYC = (BO_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_NS = 1000000000;
    localparam int RECOVER_CYC = RECOVER_NS / CLK_NS;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INTEG = 8'h08;
    localparam int CTRL_SW_DIS_BIT = 0;
    localparam logic CTRL_SW_DIS_RST = 1'h0;
    localparam int STAT_ST_LSB = 0;
    localparam int STAT_BO_BIT = 3;
    localparam int STAT_OVCNT_LSB = 4;
    localparam int STAT_STARTUP_BIT = 7;
    localparam int STAT_GATE_BIT = 8;
    localparam int STAT_CAUSE_LSB = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_WAIT = 3'h0,
        ST_RUN = 3'h1,
        ST_BROWN = 3'h2,
        ST_FAULT = 3'h3,
        ST_LATCH = 3'h4,
        ST_THERM = 3'h5
    } fpsq_state_t;

    typedef struct packed {
        logic output_overvoltage_check;
        logic line_above_start;
        logic line_below_stop;
        logic zero_cross;
        logic supply_lockout;
        logic supply_below_reset;
        logic supply_at_on;
        logic overtemp;
        logic oc_fault;
    } fpsq_cmp_t;

    typedef struct packed {
        fpsq_cmp_t s1;
        fpsq_cmp_t s2;
        logic gate_d;
        fpsq_state_t st;
        logic [7:0] blank_cnt;
        logic ov_seen;
        logic [2:0] ov_cnt;
        logic [15:0] off_cnt;
        logic long_done;
        logic [15:0] pulse_cnt;
        logic [27:0] integ;
        logic [27:0] bo_cnt;
        logic bo_flag;
        logic [27:0] rec;
        logic [2:0] cause;
        logic sw_dis;
        logic startup_en;
        logic gate_en;
        logic fault_mode;
        logic ontime_en;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fpsq_regs_t;

    localparam fpsq_regs_t REGS_RST = '{
        st: ST_WAIT, sw_dis: CTRL_SW_DIS_RST, startup_en: 1'b1,
        awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
endpackage

// >>> tb_fpsq_core.sv
// self-checking bench for the fault protection sequencer
`timescale 1ns/10ps
module tb_fpsq_core import fpsq_pkg::*;;
    localparam int RCP = 40;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    fpsq_cmp_t cmp_tb = '0;
    fpsq_cmp_t cmp_in;
    logic [15:0] off_len = 16'h0064;
    logic [15:0] ovp_at = 16'h0000;
    logic ovp_m, gate_drive, gate_en, startup_en, fault_mode, ontime_mod_en;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int miscompares = 0, checks_done = 0, cyc = 0;
    assign cmp_in = {ovp_m, cmp_tb[7:0]};
    always #4 clk_sys = ~clk_sys;

    fpsq_far_model u_fpsq_far_model (.clk_sys(clk_sys), .rst(rst),
        .gate_en(gate_en), .off_len(off_len), .ovp_at(ovp_at),
        .gate_drive(gate_drive), .output_overvoltage_check(ovp_m));
    // short counts keep the run brief; expectations scale from them
    fpsq_core #(.LONG_OFF_P(400), .SC_PULSE_P(40), .SC_REACH_P(50),
        .BO_BLANK_P(30), .RECOVER_P(RCP)) u_fpsq_core (
        .clk_sys(clk_sys), .rst(rst), .cmp_in(cmp_in),
        .gate_drive(gate_drive), .gate_en(gate_en),
        .startup_en(startup_en), .fault_mode(fault_mode),
        .ontime_mod_en(ontime_mod_en), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // sel 0 gate_en, 1 fault_mode, 2 startup_en; delay must land in lo..hi+1
    task automatic expect_out(input int sel, input logic v, input int lo,
            input int hi, input string nm);
        int t;
        logic s;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
            s = sel == 0 ? gate_en : sel == 1 ? fault_mode : startup_en;
        end while (s !== v && t <= hi);
        checks_done++;
        if (s !== v || t < lo) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                nm, lo, hi, t);
        end
    endtask

    // write offers aw and w together; bready held until bvalid seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no wait limit here: only the cycle ceiling ends a hung wait
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e, input logic [1:0] er, input string nm);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(nm, e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask

    task automatic zc();
        cmp_tb.zero_cross <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cmp_tb.zero_cross <= 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        cmp_tb.supply_at_on <= 1'b1;
        rd(REG_STATUS, 32'hFFF, 32'h080, RESP_OKAY, "status rst");
        repeat (20) @(posedge clk_sys);
        chk("gate low line", 0, gate_en);
        cmp_tb.line_above_start <= 1'b1;
        expect_out(0, 1'b1, 1, 10, "start run");
        chk("ontime", 1, ontime_mod_en);
        $display("test startup done");
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        expect_out(0, 1'b0, 1, 5, "sw disable");
        rd(REG_CTRL, 32'h1, 32'h1, RESP_OKAY, "ctrl");
        // byte lane 0 off: the disable bit must keep its value
        wstrb <= 4'hE;
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        rd(REG_CTRL, 32'h1, 32'h1, RESP_OKAY, "ctrl strobe");
        wstrb <= 4'hF;
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        expect_out(0, 1'b1, 1, 5, "sw enable");
        wr(REG_STATUS, 32'hFFFF, RESP_OKAY);
        wr(8'h10, 32'h1, RESP_SLVERR);
        rd(8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR, "unmapped");
        $display("test registers done");
        // trips inside the 250-cycle blank must never count
        off_len <= 16'd300;
        ovp_at <= 16'd50;
        repeat (1300) @(posedge clk_sys);
        chk("blanked ovp", 0, fault_mode);
        ovp_at <= 16'd270;
        expect_out(1, 1'b1, 955, 1300, "ovp fault");
        ovp_at <= 16'h0;
        off_len <= 16'd100;
        chk("ovp gate", 0, gate_en);
        rd(REG_STATUS, 32'hE77, 32'h203, RESP_OKAY, "ovp stat");
        expect_out(0, 1'b1, RCP - 10, RCP + 20, "ovp rec");
        $display("test overvoltage done");
        // off 500 > 400: one pulse per cycle, two needed at weight 20
        off_len <= 16'd500;
        expect_out(1, 1'b1, 800, 1100, "short");
        off_len <= 16'd100;
        rd(REG_STATUS, 32'hE07, 32'h403, RESP_OKAY, "short st");
        expect_out(0, 1'b1, RCP - 10, RCP + 20, "short rec");
        $display("test short done");
        cmp_tb.line_above_start <= 1'b0;
        cmp_tb.line_below_stop <= 1'b1;
        repeat (20) @(posedge clk_sys);
        cmp_tb.line_below_stop <= 1'b0;
        repeat (5) @(posedge clk_sys);
        zc();
        repeat (5) @(posedge clk_sys);
        chk("short dip", 1, gate_en);
        cmp_tb.line_below_stop <= 1'b1;
        repeat (40) @(posedge clk_sys);
        chk("bo pulses", 1, gate_en);
        rd(REG_STATUS, 32'h8, 32'h8, RESP_OKAY, "bo flag");
        zc();
        expect_out(0, 1'b0, 1, 6, "bo stop");
        cmp_tb.line_below_stop <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk("bo hold", 0, gate_en);
        cmp_tb.line_above_start <= 1'b1;
        expect_out(0, 1'b1, 1, 10, "bo exit");
        rd(REG_STATUS, 32'h8, 32'h0, RESP_OKAY, "bo clear");
        $display("test brownout done");
        cmp_tb.overtemp <= 1'b1;
        expect_out(2, 1'b0, 1, 8, "ot src");
        chk("ot gate", 0, gate_en);
        cmp_tb.supply_at_on <= 1'b0;
        cmp_tb.supply_below_reset <= 1'b1;
        expect_out(2, 1'b1, 1, 8, "ot recharge");
        cmp_tb.supply_below_reset <= 1'b0;
        cmp_tb.supply_at_on <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rd(REG_STATUS, 32'h187, 32'h5, RESP_OKAY, "ot hold");
        cmp_tb.overtemp <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("ot wait on", 0, gate_en);
        cmp_tb.supply_at_on <= 1'b0;
        cmp_tb.supply_below_reset <= 1'b1;
        repeat (5) @(posedge clk_sys);
        cmp_tb.supply_below_reset <= 1'b0;
        cmp_tb.supply_at_on <= 1'b1;
        expect_out(0, 1'b1, 1, 15, "ot restart");
        $display("test thermal done");
        cmp_tb.supply_lockout <= 1'b1;
        expect_out(1, 1'b1, 1, 8, "uvlo");
        cmp_tb.supply_lockout <= 1'b0;
        expect_out(0, 1'b1, RCP - 10, RCP + 15, "uvlo rec");
        // non-latching overcurrent: fault, cause bit 2, auto-recovery
        cmp_tb.oc_fault <= 1'b1;
        expect_out(1, 1'b1, 1, 8, "oc fault");
        cmp_tb.oc_fault <= 1'b0;
        rd(REG_STATUS, 32'hE07, 32'h803, RESP_OKAY, "oc cause");
        expect_out(0, 1'b1, RCP - 10, RCP + 20, "oc rec");
        $display("test lockout done");
        conclude();
    end
endmodule // tb_fpsq_core
